// ==== common/amsc_link_if.sv ====
// link between the host controller and the amplifier control logic
`timescale 1ns/100ps
interface amsc_link_if;
    logic pwr_down_n;
    logic audio_clk_run;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic rd_en;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic rd_valid;
    modport device (
        input pwr_down_n, audio_clk_run, wr_en, wr_addr, wr_data, rd_en, rd_addr,
        output rd_data, rd_valid
    );
    modport host (
        output pwr_down_n, audio_clk_run, wr_en, wr_addr, wr_data, rd_en, rd_addr,
        input rd_data, rd_valid
    );
endinterface

// ==== common/amsc_pkg.sv ====
// constants shared by both ends of the amplifier state and modulation control
// What this block does
// - four selectable pwm phases, 45 degrees apart
// - phase register: phase number plus sync enable
// - host halts clock, sets phase, hi-z, restarts
// - phase aligns itself when audio clock starts
// - overtemp warning makes limiter cut digital gain
// - gain ramps back after warning clears
// - foldback depth, attack, release set by software
// - power-down low: regulators off, registers default
// - host rewrites configuration after shutdown before play
// - two-bit field selects four power states
// - deep sleep: analog supply off, core on
// - host wakes deep sleep via hi-z sequence twice
// - sleep keeps analog on; play code resumes
// - hi-z floats outputs only; play code resumes
// - modulation field selects one of three schemes
// - in-phase: duties mirror around fifty percent
// - single-side: idle near 14%, falling output grounded
// - hybrid adapts duty from level and supply value
// - host hybrid wake: safe mode, 2ms, hybrid, 15ms
// - reg 0x00 selects page, 0x7f on page 0 book
// - modulation code zero means in-phase
package amsc_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_PAGE = 8'h00;
    localparam logic [7:0] REG_MOD = 8'h02;
    localparam logic [7:0] REG_PSTATE = 8'h03;
    localparam logic [7:0] REG_GAIN = 8'h4c;
    localparam logic [7:0] REG_PHASE = 8'h6a;
    localparam logic [7:0] REG_FB_DEPTH = 8'h70;
    localparam logic [7:0] REG_FB_ATTACK = 8'h71;
    localparam logic [7:0] REG_FB_RELEASE = 8'h72;
    localparam logic [7:0] REG_SUPPLY = 8'h73;
    localparam logic [7:0] REG_GAIN_NOW = 8'h74;
    localparam logic [7:0] REG_BOOK = 8'h7f;
    // ------------------------------------------------------------
    // reset values and fields
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_GAIN = 8'h80;
    localparam logic [7:0] RST_FB_DEPTH = 8'h20;
    localparam logic [7:0] RST_FB_ATTACK = 8'h01;
    localparam logic [7:0] RST_FB_RELEASE = 8'h04;
    localparam logic [7:0] RST_SUPPLY = 8'h40;
    localparam logic [1:0] PS_DEEP = 2'h0;
    localparam logic [1:0] PS_SLEEP = 2'h1;
    localparam logic [1:0] PS_HIZ = 2'h2;
    localparam logic [1:0] PS_PLAY = 2'h3;
    localparam logic [1:0] MOD_IN_PHASE = 2'h0;
    localparam logic [1:0] MOD_SINGLE = 2'h1;
    localparam logic [1:0] MOD_HYBRID = 2'h2;
    localparam int PHASE_SYNC_BIT = 0;
    localparam int PHASE_LO = 2;
    // ------------------------------------------------------------
    // pwm and timing
    // ------------------------------------------------------------
    localparam logic [7:0] PHASE_STEP = 8'h20;
    localparam logic [8:0] DUTY_MID = 9'h080;
    localparam logic [8:0] DUTY_IDLE = 9'h024;
    localparam int GAIN_SHIFT = 7;
    localparam logic [7:0] RATE_UNIT = 8'h00;
    localparam int CLK_HZ = 50_000_000;
    localparam int DELAY_SHORT_MS = 2;
    localparam int DELAY_LONG_MS = 15;
    localparam int DELAY_SHORT_CYC = DELAY_SHORT_MS * (CLK_HZ / 1000);
    localparam int DELAY_LONG_CYC = DELAY_LONG_MS * (CLK_HZ / 1000);
    // ------------------------------------------------------------
    // host sequencer
    // ------------------------------------------------------------
    localparam logic [2:0] CMD_STARTUP = 3'h1;
    localparam logic [2:0] CMD_WAKE = 3'h2;
    localparam logic [2:0] CMD_HYBRID = 3'h3;
    localparam logic [2:0] CMD_RESTORE = 3'h4;
    localparam logic [2:0] CMD_READ = 3'h5;
    localparam logic [2:0] K_END = 3'h0;
    localparam logic [2:0] K_WRITE = 3'h1;
    localparam logic [2:0] K_WAIT_S = 3'h2;
    localparam logic [2:0] K_WAIT_L = 3'h3;
    localparam logic [2:0] K_CLK_OFF = 3'h4;
    localparam logic [2:0] K_CLK_ON = 3'h5;
    localparam logic [2:0] K_READ = 3'h6;
    localparam logic [7:0] APB_CTRL = 8'h00;
    localparam logic [7:0] APB_CFG = 8'h04;
    localparam logic [7:0] APB_CMD = 8'h08;
    localparam logic [7:0] APB_STATUS = 8'h0c;
    typedef enum logic [3:0] {
        HS_IDLE = 4'b0001,
        HS_RUN = 4'b0010,
        HS_DELAY = 4'b0100,
        HS_READ = 4'b1000
    } amsc_hstate_type;
endpackage

// ==== core/amsc_device.sv ====
// amplifier end: registers, power states, foldback, phase sync, modulation
`timescale 1ns/100ps
module amsc_device (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // link to host
    amsc_link_if.device link,
    // protection and audio
    input wire logic overtemp_warning,
    input wire logic signed [7:0] audio_sample,
    // power stage
    output logic positive_output,
    output logic negative_output,
    output logic output_drive_en,
    output logic analog_ldo_en,
    output logic core_ldo_en,
    // status
    output logic [7:0] digital_gain_now,
    output logic phase_aligned
);
    import amsc_pkg::*;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0] page, book, mod_ctrl, pstate_ctrl, phase_ctrl;
    logic [7:0] gain_set, fb_depth, fb_attack, fb_release, supply_val;
    logic [7:0] next_rd_data;

    // power-down acts like a reset on every register
    wire clr = rst | ~link.pwr_down_n;
    wire on_base = (page == RST_ZERO) && (book == RST_ZERO);
    wire wr_base = link.wr_en & on_base;
    wire wr_page = link.wr_en & (link.wr_addr == REG_PAGE);
    wire wr_book = link.wr_en & (page == RST_ZERO) & (link.wr_addr == REG_BOOK);
    wire wr_mod = wr_base & (link.wr_addr == REG_MOD);
    wire wr_pstate = wr_base & (link.wr_addr == REG_PSTATE);
    wire wr_phase = wr_base & (link.wr_addr == REG_PHASE);
    wire wr_gain = wr_base & (link.wr_addr == REG_GAIN);
    wire wr_depth = wr_base & (link.wr_addr == REG_FB_DEPTH);
    wire wr_attack = wr_base & (link.wr_addr == REG_FB_ATTACK);
    wire wr_release = wr_base & (link.wr_addr == REG_FB_RELEASE);
    wire wr_supply = wr_base & (link.wr_addr == REG_SUPPLY);

    always_ff @(posedge ref_clk) begin
        if (clr) begin
            page <= RST_ZERO;
            book <= RST_ZERO;
            mod_ctrl <= RST_ZERO;
            pstate_ctrl <= RST_ZERO;
            phase_ctrl <= RST_ZERO;
            gain_set <= RST_GAIN;
            fb_depth <= RST_FB_DEPTH;
            fb_attack <= RST_FB_ATTACK;
            fb_release <= RST_FB_RELEASE;
            supply_val <= RST_SUPPLY;
        end else begin
            if (wr_page) page <= link.wr_data;
            if (wr_book) book <= link.wr_data;
            if (wr_mod) mod_ctrl <= link.wr_data;
            if (wr_pstate) pstate_ctrl <= link.wr_data;
            if (wr_phase) phase_ctrl <= link.wr_data;
            if (wr_gain) gain_set <= link.wr_data;
            if (wr_depth) fb_depth <= link.wr_data;
            if (wr_attack) fb_attack <= link.wr_data;
            if (wr_release) fb_release <= link.wr_data;
            if (wr_supply) supply_val <= link.wr_data;
        end
    end

    // reads outside book 0 page 0 return only page, and book while page is 0
    always_comb begin
        next_rd_data = RST_ZERO;
        if (link.rd_addr == REG_PAGE) next_rd_data = page;
        else if (link.rd_addr == REG_BOOK && page == RST_ZERO) next_rd_data = book;
        else if (on_base) begin
            case (link.rd_addr)
                REG_MOD: next_rd_data = mod_ctrl;
                REG_PSTATE: next_rd_data = pstate_ctrl;
                REG_PHASE: next_rd_data = phase_ctrl;
                REG_GAIN: next_rd_data = gain_set;
                REG_FB_DEPTH: next_rd_data = fb_depth;
                REG_FB_ATTACK: next_rd_data = fb_attack;
                REG_FB_RELEASE: next_rd_data = fb_release;
                REG_SUPPLY: next_rd_data = supply_val;
                REG_GAIN_NOW: next_rd_data = digital_gain_now;
                default: next_rd_data = RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (clr) begin
            link.rd_data <= RST_ZERO;
            link.rd_valid <= 1'b0;
        end else begin
            link.rd_data <= next_rd_data;
            link.rd_valid <= link.rd_en;
        end
    end

    // ------------------------------------------------------------
    // power states
    // ------------------------------------------------------------
    wire [1:0] pstate = pstate_ctrl[1:0];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            output_drive_en <= 1'b0;
            analog_ldo_en <= 1'b0;
            core_ldo_en <= 1'b0;
        end else begin
            core_ldo_en <= link.pwr_down_n;
            analog_ldo_en <= link.pwr_down_n & (pstate != PS_DEEP);
            // outside play the drivers float, and deep sleep also drops the analog supply; the core keeps running
            output_drive_en <= link.pwr_down_n & (pstate == PS_PLAY);
        end
    end

    // ------------------------------------------------------------
    // thermal foldback
    // ------------------------------------------------------------
    logic [15:0] ramp_cnt;
    wire [7:0] fold_gain = (gain_set > fb_depth) ? gain_set - fb_depth : RST_ZERO;
    wire [7:0] gain_target = overtemp_warning ? fold_gain : gain_set;
    wire [7:0] ramp_rate = overtemp_warning ? fb_attack : fb_release;
    wire [15:0] ramp_len = {ramp_rate, RATE_UNIT};
    wire ramp_tick = (ramp_cnt >= ramp_len);

    // one gain step per rate interval, so recovery is gradual
    always_ff @(posedge ref_clk) begin
        if (clr) begin
            ramp_cnt <= 16'h0000;
            digital_gain_now <= RST_GAIN;
        end else if (digital_gain_now == gain_target) begin
            ramp_cnt <= 16'h0000;
        end else if (ramp_tick) begin
            ramp_cnt <= 16'h0000;
            if (digital_gain_now > gain_target)
                digital_gain_now <= digital_gain_now - 8'h01;
            else
                digital_gain_now <= digital_gain_now + 8'h01;
        end else begin
            ramp_cnt <= ramp_cnt + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // pwm carrier and phase sync
    // ------------------------------------------------------------
    logic [7:0] pwm_cnt;
    logic clk_run_d;
    wire [1:0] phase_sel = phase_ctrl[PHASE_LO +: 2];
    wire sync_en = phase_ctrl[PHASE_SYNC_BIT];
    wire [7:0] phase_offset = 8'(phase_sel * PHASE_STEP);
    wire clk_start = link.audio_clk_run & ~clk_run_d;

    always_ff @(posedge ref_clk) begin
        if (clr) begin
            clk_run_d <= 1'b0;
            pwm_cnt <= 8'h00;
            phase_aligned <= 1'b0;
        end else begin
            clk_run_d <= link.audio_clk_run;
            if (clk_start && sync_en) begin
                pwm_cnt <= phase_offset;
                phase_aligned <= 1'b1;
            end else begin
                if (link.audio_clk_run) pwm_cnt <= pwm_cnt + 8'h01;
                // a new phase choice needs a fresh clock start to take hold
                if (wr_phase) phase_aligned <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // modulation
    // ------------------------------------------------------------
    wire signed [16:0] prod = audio_sample * $signed({1'b0, digital_gain_now});
    wire signed [9:0] scaled = prod[16:GAIN_SHIFT];
    wire signed [9:0] lvl_hi = 10'sd127;
    wire signed [9:0] lvl_lo = -10'sd127;
    wire signed [9:0] level = (scaled > lvl_hi) ? lvl_hi : (scaled < lvl_lo) ? lvl_lo : scaled;
    wire [8:0] mag = level[9] ? 9'(-level) : 9'(level);
    wire signed [10:0] ip_p = $signed({2'b00, DUTY_MID}) + 11'(level);
    wire signed [10:0] ip_n = $signed({2'b00, DUTY_MID}) - 11'(level);
    wire signed [10:0] ss_p = $signed({2'b00, DUTY_IDLE}) + 11'(level);
    wire signed [10:0] ss_n = $signed({2'b00, DUTY_IDLE}) - 11'(level);
    // the falling side clamps to zero, i.e. rails to ground
    wire [8:0] ss_p_c = ss_p[10] ? 9'h000 : ss_p[8:0];
    wire [8:0] ss_n_c = ss_n[10] ? 9'h000 : ss_n[8:0];
    // small signals run single-side, large ones in-phase
    wire hyb_small = (mag < {1'b0, supply_val});
    wire [1:0] mod_sel = mod_ctrl[1:0];
    wire use_single = (mod_sel == MOD_SINGLE) || (mod_sel == MOD_HYBRID && hyb_small);
    wire [8:0] duty_p = use_single ? ss_p_c : ip_p[8:0];
    wire [8:0] duty_n = use_single ? ss_n_c : ip_n[8:0];

    always_ff @(posedge ref_clk) begin
        if (clr) begin
            positive_output <= 1'b0;
            negative_output <= 1'b0;
        end else begin
            positive_output <= output_drive_en & link.audio_clk_run & ({1'b0, pwm_cnt} < duty_p);
            negative_output <= output_drive_en & link.audio_clk_run & ({1'b0, pwm_cnt} < duty_n);
        end
    end
endmodule

// ==== core/amsc_host.sv ====
// host end: apb command registers and a sequencer that drives the link
//
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
module amsc_host #(
    parameter int DELAY_SHORT = amsc_pkg::DELAY_SHORT_CYC,
    parameter int DELAY_LONG = amsc_pkg::DELAY_LONG_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link to amplifier
    amsc_link_if.host link
);
    import amsc_pkg::*;

    // ------------------------------------------------------------
    // step table
    // ------------------------------------------------------------
    function automatic logic [18:0] step_of(input logic [2:0] cmd, input logic [3:0] idx,
                                            input logic [7:0] phs, input logic [7:0] md,
                                            input logic [7:0] ra);
        logic [7:0] md_safe;
        logic [7:0] md_hyb;
        logic [18:0] s;
        md_safe = {md[7:2], MOD_SINGLE};
        md_hyb = {md[7:2], MOD_HYBRID};
        s = {K_END, RST_ZERO, RST_ZERO};
        case (idx)
            4'h0: s = (cmd == CMD_STARTUP) ? {K_CLK_OFF, RST_ZERO, RST_ZERO} :
                      (cmd == CMD_HYBRID) ? {K_WRITE, REG_MOD, md_safe} :
                      {K_WRITE, REG_PAGE, RST_ZERO};
            4'h1: s = (cmd == CMD_HYBRID) ? {K_WRITE, REG_PSTATE, 6'h00, PS_HIZ} :
                      (cmd == CMD_STARTUP) ? {K_WRITE, REG_PAGE, RST_ZERO} :
                      {K_WRITE, REG_BOOK, RST_ZERO};
            4'h2: s = (cmd == CMD_HYBRID) ? {K_WAIT_S, RST_ZERO, RST_ZERO} :
                      (cmd == CMD_STARTUP) ? {K_WRITE, REG_BOOK, RST_ZERO} :
                      (cmd == CMD_WAKE) ? {K_WRITE, REG_PSTATE, 6'h00, PS_HIZ} :
                      (cmd == CMD_RESTORE) ? {K_WRITE, REG_MOD, md} :
                      {K_READ, ra, RST_ZERO};
            4'h3: s = (cmd == CMD_HYBRID) ? {K_WRITE, REG_MOD, md_hyb} :
                      (cmd == CMD_WAKE) ? {K_WRITE, REG_PSTATE, 6'h00, PS_DEEP} :
                      (cmd == CMD_READ) ? {K_END, RST_ZERO, RST_ZERO} :
                      {K_WRITE, REG_PHASE, phs};
            4'h4: s = (cmd == CMD_HYBRID) ? {K_WAIT_L, RST_ZERO, RST_ZERO} :
                      (cmd == CMD_WAKE) ? {K_WRITE, REG_PAGE, RST_ZERO} :
                      {K_WRITE, REG_PSTATE, 6'h00, PS_HIZ};
            4'h5: s = (cmd == CMD_HYBRID) ? {K_WRITE, REG_PSTATE, 6'h00, PS_PLAY} :
                      (cmd == CMD_WAKE) ? {K_WRITE, REG_BOOK, RST_ZERO} :
                      (cmd == CMD_STARTUP) ? {K_CLK_ON, RST_ZERO, RST_ZERO} :
                      {K_WRITE, REG_PSTATE, 6'h00, PS_PLAY};
            4'h6: s = (cmd == CMD_WAKE) ? {K_WRITE, REG_PSTATE, 6'h00, PS_HIZ} :
                      {K_END, RST_ZERO, RST_ZERO};
            4'h7: s = (cmd == CMD_WAKE) ? {K_WRITE, REG_PSTATE, 6'h00, PS_PLAY} :
                      {K_END, RST_ZERO, RST_ZERO};
            default: s = {K_END, RST_ZERO, RST_ZERO};
        endcase
        return s;
    endfunction

    // ------------------------------------------------------------
    // apb registers
    // ------------------------------------------------------------
    logic power_up, clk_run;
    logic [7:0] phase_cfg, mod_cfg, rd_addr_cfg, rd_result;
    logic [2:0] cmd;
    logic [3:0] idx;
    logic [19:0] delay_cnt;
    amsc_hstate_type hstate;

    wire busy = (hstate != HS_IDLE);
    wire setup = psel & ~penable;
    wire access_wr = psel & penable & pwrite;
    wire mapped = (paddr == APB_CTRL) || (paddr == APB_CFG) || (paddr == APB_CMD) ||
                  (paddr == APB_STATUS);
    // a command arriving while busy is dropped
    wire cmd_go = access_wr & (paddr == APB_CMD) & ~busy;
    wire [18:0] step = step_of(cmd, idx, phase_cfg, mod_cfg, rd_addr_cfg);
    wire [2:0] kind = step[18:16];

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            case (paddr)
                APB_CTRL: prdata <= {30'h0, clk_run, power_up};
                APB_CFG: prdata <= {16'h0, mod_cfg, phase_cfg};
                APB_CMD: prdata <= {16'h0, rd_addr_cfg, 5'h00, cmd};
                APB_STATUS: prdata <= {16'h0, rd_result, 7'h00, busy};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            power_up <= 1'b0;
            phase_cfg <= RST_ZERO;
            mod_cfg <= RST_ZERO;
            rd_addr_cfg <= RST_ZERO;
        end else if (access_wr && paddr == APB_CTRL) begin
            power_up <= pwdata[0];
        end else if (access_wr && paddr == APB_CFG && !busy) begin
            phase_cfg <= pwdata[7:0];
            mod_cfg <= pwdata[15:8];
        end else if (cmd_go) begin
            rd_addr_cfg <= pwdata[15:8];
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hstate <= HS_IDLE;
            cmd <= 3'h0;
            idx <= 4'h0;
            delay_cnt <= 20'h00000;
            clk_run <= 1'b0;
            rd_result <= RST_ZERO;
            link.wr_en <= 1'b0;
            link.wr_addr <= RST_ZERO;
            link.wr_data <= RST_ZERO;
            link.rd_en <= 1'b0;
            link.rd_addr <= RST_ZERO;
        end else begin
            link.wr_en <= 1'b0;
            link.rd_en <= 1'b0;
            case (hstate)
                HS_IDLE: begin
                    if (access_wr && paddr == APB_CTRL) clk_run <= pwdata[1];
                    if (cmd_go) begin
                        cmd <= pwdata[2:0];
                        idx <= 4'h0;
                        hstate <= HS_RUN;
                    end
                end
                HS_RUN: begin
                    idx <= idx + 4'h1;
                    case (kind)
                        K_WRITE: begin
                            link.wr_en <= 1'b1;
                            link.wr_addr <= step[15:8];
                            link.wr_data <= step[7:0];
                        end
                        K_WAIT_S: begin
                            delay_cnt <= 20'(DELAY_SHORT);
                            hstate <= HS_DELAY;
                        end
                        K_WAIT_L: begin
                            delay_cnt <= 20'(DELAY_LONG);
                            hstate <= HS_DELAY;
                        end
                        K_CLK_OFF: clk_run <= 1'b0;
                        K_CLK_ON: clk_run <= 1'b1;
                        K_READ: begin
                            link.rd_en <= 1'b1;
                            link.rd_addr <= step[15:8];
                            hstate <= HS_READ;
                        end
                        default: hstate <= HS_IDLE;
                    endcase
                end
                HS_DELAY: begin
                    if (delay_cnt <= 20'h00001) hstate <= HS_RUN;
                    else delay_cnt <= delay_cnt - 20'h00001;
                end
                HS_READ: begin
                    if (link.rd_valid) begin
                        rd_result <= link.rd_data;
                        hstate <= HS_RUN;
                    end
                end
                default: hstate <= HS_IDLE;
            endcase
        end
    end

    assign link.pwr_down_n = power_up;
    assign link.audio_clk_run = clk_run;
endmodule

// ==== test/amsc_assertions.sv ====
// checker on the link and the power stage
`timescale 1ns/100ps
module amsc_assertions (
    input logic ref_clk, rst, pwr_down_n, audio_clk_run, rd_en, rd_valid, phase_aligned,
    input logic overtemp_warning, positive_output, negative_output, output_drive_en,
    input logic analog_ldo_en, core_ldo_en, input logic [7:0] digital_gain_now
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    AST_RD_ANSWER: assert property (rd_en && pwr_down_n |=> rd_valid)
        else $error("read unanswered");
    AST_SHUT_LDO: assert property (!pwr_down_n |=> !core_ldo_en && !analog_ldo_en)
        else $error("ldo on in shutdown");
    AST_SHUT_GAIN: assert property (!pwr_down_n |=> digital_gain_now == 8'h80)
        else $error("gain kept");
    AST_DRV_ANALOG: assert property (output_drive_en |-> analog_ldo_en)
        else $error("drive without analog");
    AST_HIZ_QUIET: assert property (!output_drive_en [*2] |->
        !positive_output && !negative_output) else $error("pwm in hi-z");
    AST_ALIGN: assert property ($rose(phase_aligned) |->
        $past(audio_clk_run) && !$past(audio_clk_run, 2)) else $error("align off start");
    AST_GAIN_STEP: assert property (pwr_down_n && $past(pwr_down_n) |->
        8'(digital_gain_now - $past(digital_gain_now)) inside {8'h00, 8'h01, 8'hff})
        else $error("gain jumped");
    AST_WARN_HOLD: assert property (overtemp_warning [*3] |->
        digital_gain_now <= $past(digital_gain_now)) else $error("gain rose");
    cover property ($rose(phase_aligned));
    cover property (overtemp_warning && digital_gain_now == 8'h60);
    cover property ($fell(pwr_down_n));
endmodule

// ==== test/tb_amp_state_and_modulation_ctrl.sv ====
// apb-driven bench with host and amplifier joined over the link
`timescale 1ns/100ps
module tb_amp_state_and_modulation_ctrl;
    import amsc_pkg::*;
    logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, overtemp_warning = 0;
    logic err, pready, pslverr, positive_output, negative_output, output_drive_en;
    logic analog_ldo_en, core_ldo_en, phase_aligned;
    logic [7:0] np, nn;
    logic [7:0] paddr = 8'h00, digital_gain_now;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic signed [7:0] audio_sample = 8'sh10;
    int n_fail = 0, check_count = 0, cyc = 0;
    amsc_link_if link ();
    amsc_host #(.DELAY_SHORT(20), .DELAY_LONG(50)) amsc_host_inst (.ref_clk(ref_clk),
        .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link(link.host));
    amsc_device amsc_device_inst (.ref_clk(ref_clk), .rst(rst), .link(link.device),
        .overtemp_warning(overtemp_warning), .audio_sample(audio_sample),
        .positive_output(positive_output), .negative_output(negative_output),
        .output_drive_en(output_drive_en), .analog_ldo_en(analog_ldo_en),
        .core_ldo_en(core_ldo_en), .digital_gain_now(digital_gain_now),
        .phase_aligned(phase_aligned));
    amsc_assertions amsc_assertions_inst (.ref_clk(ref_clk), .rst(rst),
        .pwr_down_n(link.pwr_down_n), .audio_clk_run(link.audio_clk_run),
        .rd_en(link.rd_en), .rd_valid(link.rd_valid), .phase_aligned(phase_aligned),
        .overtemp_warning(overtemp_warning), .positive_output(positive_output),
        .negative_output(negative_output), .output_drive_en(output_drive_en),
        .analog_ldo_en(analog_ldo_en), .core_ldo_en(core_ldo_en),
        .digital_gain_now(digital_gain_now));
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (++cyc == 60000) begin n_fail++; summarize(); end
    task apb(input logic w, logic [7:0] a, logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk) penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rdata = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task cmd(input logic [7:0] ra, logic [2:0] c);
        apb(1'b1, APB_CMD, {16'h0, ra, 5'h0, c});
        do apb(1'b0, APB_STATUS, 32'h0); while (rdata[0] !== 1'b0);
    endtask
    // high cycles over one full pwm period, sampled away from the launching edge
    task duty;
        np = 8'h00;
        nn = 8'h00;
        repeat (2) @(posedge ref_clk);
        repeat (256) begin
            @(negedge ref_clk);
            np += {7'h0, positive_output};
            nn += {7'h0, negative_output};
        end
        @(posedge ref_clk);
    endtask
    task chk(input string s, logic [7:0] e, logic [7:0] g);
        check_count++;
        if (g !== e) begin n_fail++; $display("Error %s exp %h got %h", s, e, g); end
    endtask
    task summarize;
        if (n_fail == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b1, APB_CFG, 32'h107);
        apb(1'b1, APB_CTRL, 32'h1);
        cmd(8'h00, CMD_STARTUP);
        chk("align", 8'h1, {7'h0, phase_aligned});
        cmd(REG_PHASE, CMD_READ);
        chk("phase", 8'h07, rdata[15:8]);
        overtemp_warning <= 1'b1;
        repeat (9000) @(posedge ref_clk);
        chk("cut", RST_GAIN - RST_FB_DEPTH, digital_gain_now);
        overtemp_warning <= 1'b0;
        repeat (34000) @(posedge ref_clk);
        chk("back", RST_GAIN, digital_gain_now);
        cmd(8'h00, CMD_HYBRID);
        chk("play", 8'h1, {7'h0, output_drive_en});
        cmd(REG_MOD, CMD_READ);
        chk("mod", {6'h0, MOD_HYBRID}, rdata[15:8]);
        duty();
        chk("hyb_small_p", 8'h34, np);
        chk("hyb_small_n", 8'h14, nn);
        audio_sample <= 8'sh60;
        duty();
        chk("hyb_large_p", 8'he0, np);
        chk("hyb_large_n", 8'h20, nn);
        apb(1'b1, APB_CFG, 32'h107);
        cmd(8'h00, CMD_RESTORE);
        duty();
        chk("single_p", 8'h84, np);
        chk("single_n", 8'h00, nn);
        audio_sample <= 8'sh10;
        apb(1'b1, APB_CFG, 32'h7);
        cmd(8'h00, CMD_RESTORE);
        duty();
        chk("inphase_p", 8'h90, np);
        chk("inphase_n", 8'h70, nn);
        cmd(8'h00, CMD_WAKE);
        chk("wake", 8'h1, {7'h0, output_drive_en});
        apb(1'b1, APB_CTRL, 32'h0);
        repeat (2) @(posedge ref_clk);
        chk("ldo", 8'h0, {7'h0, core_ldo_en});
        chk("aldo", 8'h0, {7'h0, analog_ldo_en});
        apb(1'b1, APB_CTRL, 32'h1);
        cmd(REG_PHASE, CMD_READ);
        chk("dflt", 8'h00, rdata[15:8]);
        apb(1'b0, 8'h10, 32'h0);
        chk("slverr", 8'h1, {7'h0, err});
        summarize();
    end
endmodule
